// *** sim/sns_master.sv ***
module sns_master (
  // clock of the bench
  input  wire logic clk,
  // resolved serial wire
  input  wire logic sda,
  // master drive, sdaDrv low pulls the wire
  output logic      scl,
  output logic      sdaDrv
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // start, also usable as repeated start after an ack clock
  task automatic start();
    tick(3);
    sdaDrv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sdaDrv <= 1'b0;
    tick(3);
    scl <= 1'b0;
  endtask

  // one clock: data set mid-low, sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sdaDrv <= b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(1);
    scl <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~ackIt, r);
  endtask

  // stop only after the data line is back with the master
  task automatic stop();
    tick(2);
    sdaDrv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sdaDrv <= 1'b1;
    tick(4);
  endtask
endmodule

// *** sim/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int         WC  = 40;
  localparam logic [3:0] DT  = 4'h5;
  localparam logic [1:0] SEL = 2'h2;

  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       writeProtect = 1'b0;
  logic       lowSupply = 1'b0;
  logic       chipEnN = 1'b1;
  logic       readEnN = 1'b1;
  logic       writeEnN = 1'b1;
  logic       tbOe = 1'b0;
  logic [3:0] tbNib = 4'h0;
  logic [1:0] selPins = SEL;
  logic       scl, sdaDrv, sdaOut, sdaOe, resetN, capOn, standby, nibOe;
  logic [3:0] nibOut, mirr;
  int         nFail = 0;
  int         checkCount = 0;
  wire        sda = sdaDrv & ~(sdaOe & ~sdaOut);
  wire  [3:0] nib = nibOe ? nibOut : (tbOe ? tbNib : ~tbNib);

  always #20 clk = ~clk;

  sns_supervisor #(.DEVICE_TYPE(DT), .WRITE_CYCLES(WC)) u_sns_supervisor (
    .clk(clk), .rstn(rstn), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .busSelectInputs(selPins), .writeProtect(writeProtect), .lowSupply(lowSupply),
    .resetN(resetN), .backupCapacitorPin(capOn), .standbyMode(standby),
    .chipEnN(chipEnN), .readEnN(readEnN), .writeEnN(writeEnN), .nibbleDataIn(nib),
    .nibbleDataOut(nibOut), .nibbleDataOe(nibOe), .mirroredOutputPorts(mirr));

  sns_master u_sns_master (.clk(clk), .sda(sda), .scl(scl), .sdaDrv(sdaDrv));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // start plus slave byte
  task automatic slave(input logic [8:0] a, input logic rw, output logic ack);
    sns_pkg::sns_devaddr_s sb;
    sb = '{typeId: DT, sel: SEL, addrMsb: a[8], rw: rw};
    u_sns_master.start();
    u_sns_master.wr(sb, ack);
  endtask

  task automatic wrSeq(input logic [8:0] a, input logic [31:0] d, input int n,
                       output logic ak);
    logic x;
    slave(a, 1'b0, ak);
    u_sns_master.wr(a[7:0], x);
    ak = ak & x;
    for (int i = 0; i < n; i++) begin
      u_sns_master.wr(d[31-8*i -: 8], x);
      ak = ak & x;
    end
    u_sns_master.stop();
  endtask

  // random read of n bytes, first byte in d[31:24]
  task automatic rdAt(input logic [8:0] a, input int n, output logic [31:0] d);
    logic x;
    slave(a, 1'b0, x);
    u_sns_master.wr(a[7:0], x);
    slave(a, 1'b1, x);
    for (int i = 0; i < n; i++) begin
      u_sns_master.rd(i < n - 1, d[31-8*i -: 8]);
    end
    u_sns_master.stop();
  endtask

  task automatic nibWr(input logic [3:0] v);
    tbNib <= v;
    tbOe <= 1'b1;
    chipEnN <= 1'b0;
    writeEnN <= 1'b0;
    tick(4);
    chipEnN <= 1'b1;
    writeEnN <= 1'b1;
    tbOe <= 1'b0;
    tick(6);
  endtask

  task automatic t_nibble();
    chk(resetN, 1'b1, "reset out low at start");
    chk(mirr, sns_pkg::NIB_RESET, "ports not cleared");
    nibWr(4'hc);
    chk(mirr, 4'hc, "ports do not follow nibble");
    chipEnN <= 1'b0;
    readEnN <= 1'b0;
    tick(6);
    chk(nibOe, 1'b1, "nibble not driven on read");
    chk(nib, 4'hc, "nibble read value");
    chipEnN <= 1'b1;
    readEnN <= 1'b1;
    tick(6);
    chk(nibOe, 1'b0, "nibble still driven");
    $display("test nibble done");
  endtask

  task automatic t_page();
    logic        ak;
    logic [31:0] d;
    wrSeq(9'h02f, 32'hc0c1c2c3, 4, ak);
    chk(ak, 1'b1, "page write bytes not acked");
    slave(9'h000, 1'b0, ak);
    chk(ak, 1'b0, "acked while busy");
    u_sns_master.stop();
    tick(WC + 30);
    chk(standby, 1'b1, "no standby after write cycle");
    rdAt(9'h020, 2, d);
    chk(d[31:16], 16'hc1c2, "wrapped bytes or sequential read");
    slave(9'h000, 1'b1, ak);
    u_sns_master.rd(1'b0, d[7:0]);
    u_sns_master.stop();
    chk(d[7:0], 8'hc3, "current address read");
    rdAt(9'h02f, 1, d);
    chk(d[31:24], 8'hc0, "first page byte");
    $display("test page done");
  endtask

  task automatic t_select();
    logic ak;
    selPins <= ~SEL;
    u_sns_master.start();
    u_sns_master.wr({DT, SEL, 2'b00}, ak);
    chk(ak, 1'b0, "select pins ignored");
    selPins <= SEL;
    u_sns_master.start();
    u_sns_master.wr({DT, ~SEL, 2'b00}, ak);
    chk(ak, 1'b0, "wrong select acked");
    u_sns_master.start();
    u_sns_master.wr({~DT, SEL, 2'b00}, ak);
    chk(ak, 1'b0, "wrong type acked");
    u_sns_master.stop();
    $display("test select done");
  endtask

  task automatic t_protect();
    logic        ak;
    logic [31:0] d;
    wrSeq(9'h1a0, 32'h5a000000, 1, ak);
    tick(WC + 30);
    writeProtect <= 1'b1;
    wrSeq(9'h1a0, 32'ha5000000, 1, ak);
    chk(ak, 1'b0, "protected write acked");
    slave(9'h1a0, 1'b0, ak);
    chk(ak, 1'b1, "write cycle after refused write");
    u_sns_master.stop();
    writeProtect <= 1'b0;
    rdAt(9'h1a0, 1, d);
    chk(d[31:24], 8'h5a, "protected byte changed");
    $display("test protect done");
  endtask

  task automatic t_power();
    logic        ak;
    logic [31:0] d;
    int          n;
    nibWr(4'h9);
    wrSeq(9'h040, 32'h77000000, 1, ak);
    lowSupply <= 1'b1;
    n = 0;
    while (capOn !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    chk(n >= 25 && n < 500, 1'b1, "store not after write cycle");
    chk(resetN, 1'b0, "reset out not active");
    slave(9'h000, 1'b0, ak);
    chk(ak, 1'b0, "acked in low supply");
    u_sns_master.stop();
    nibWr(4'h3);
    chk(mirr, 4'h9, "nibble written in low supply");
    n = 0;
    while (capOn !== 1'b0 && n < 500) begin
      tick(1);
      n++;
    end
    lowSupply <= 1'b0;
    tick(12);
    chk(mirr, 4'h9, "nibble not recalled");
    chk(resetN, 1'b1, "reset out stuck");
    rdAt(9'h040, 1, d);
    chk(d[31:24], 8'h77, "write cycle lost");
    slave(9'h040, 1'b0, ak);
    lowSupply <= 1'b1;
    tick(6);
    chk(capOn, 1'b1, "no store from a running command");
    u_sns_master.wr(8'h40, ak);
    chk(ak, 1'b0, "command not aborted");
    u_sns_master.stop();
    n = 0;
    while (capOn !== 1'b0 && n < 500) begin
      tick(1);
      n++;
    end
    lowSupply <= 1'b0;
    tick(12);
    chk(mirr, 4'h9, "nibble lost over second power fail");
    $display("test power done");
  endtask

  initial begin
    tick(8);
    rstn <= 1'b1;
    tick(6);
    t_nibble();
    t_page();
    t_select();
    t_protect();
    t_power();
    tally_and_finish();
  end

  initial begin
    tick(30000);
    nFail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule

// *** verilog/sns_mem.sv ***
module sns_mem #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // write side
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // read side, registered
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdData_ff;

  assign rdData = rdData_ff;

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= mem[rdAddr];
    end
  end

endmodule

// *** verilog/sns_pkg.sv ***
package sns_pkg;

  // clock and nonvolatile write timing
  localparam int CLK_MHZ    = 25;
  localparam int TWC_US     = 5000;
  localparam int TWC_CYCLES = TWC_US * CLK_MHZ;
  localparam int TIMER_W    = 17;

  // array geometry
  localparam int ARRAY_AW = 9;
  localparam int PAGE_AW  = 4;
  localparam int BYTE_W   = 8;
  localparam int NIB_W    = 4;

  localparam logic [4:0] PAGE_BYTES = 5'h10;
  localparam logic [3:0] BIT_ACK    = 4'h8;
  localparam logic [3:0] BIT_END    = 4'h9;

  // reset values
  localparam logic [3:0] NIB_RESET  = 4'h0;
  localparam logic [8:0] ADDR_RESET = 9'h000;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_ADDR    = 3'b001,
    S_WORD    = 3'b010,
    S_WDATA   = 3'b011,
    S_RDATA   = 3'b100,
    S_NVWRITE = 3'b101,
    S_STORE   = 3'b110,
    S_DOWN    = 3'b111
  } sns_state_e;

  typedef struct packed {
    logic chipEnN;
    logic readEnN;
    logic writeEnN;
  } sns_strobe_s;

  typedef struct packed {
    logic        scl;
    logic        sda;
    logic        wp;
    logic [1:0]  sel;
    logic        low;
    sns_strobe_s strb;
    logic [3:0]  nib;
  } sns_pins_s;

  // bus idle, supply good, strobes inactive
  localparam sns_pins_s PINS_IDLE = 13'h1870;

  typedef struct packed {
    logic [3:0] typeId;
    logic [1:0] sel;
    logic       addrMsb;
    logic       rw;
  } sns_devaddr_s;

endpackage

// *** verilog/sns_supervisor.sv ***
// What this block does
// (RULE1) address counter spans the whole array so sequential reads run through it
// (RULE2) current-address read starts one past the last byte read or written
// (RULE3) after one full address a write takes up to a page of data bytes
// (RULE4) write-protect high refuses every write into the upper array half
// (RULE5) one separate nibble of static storage, parallel access by strobes
// (RULE6) nibble saved to shadow only on power fail, recalled only on power return
// (RULE7) four output ports always show the nibble bits
// (RULE8) low supply drives the active-low reset output
// (RULE9) low supply starts the capacitor-powered store of the nibble
// (RULE10) low supply aborts any serial command and blocks new ones
// (RULE11) a running serial write cycle finishes before the nibble store
// (RULE12) master makes every transfer and the clock; device only a slave
// (RULE13) data line changes only while clock low except start and stop
// (RULE14) the serial link is ignored until a start condition is seen
// (RULE15) stop ends communication and puts device into standby after reads
// (RULE16) master issues stop only once the transmitter released data
// (RULE17) transmitter releases after eight bits; receiver pulls low on ninth
// (RULE18) slave byte acked only on type and select match; word byte acked, data bytes unless protected
// (RULE19) no slave byte acknowledge while a nonvolatile write runs
// (RULE20) read: send byte, sample ack, continue on ack, stop on none
// (RULE21) master ends a read with no-ack then stop
// (RULE22) slave byte: type id, two select bits, address msb, read bit
// (RULE23) write cycle starts at stop; serial inputs ignored, data floated meanwhile
// (RULE24) protected write gets no ack and leaves the array unchanged
// (RULE25) page write wraps low address bits, page address stays fixed
// (RULE26) nibble drives lines on chip and read enable low, latches on write
module sns_supervisor #(
  parameter logic [3:0]  DEVICE_TYPE  = 4'h5,  // arbitrary value
  parameter int unsigned WRITE_CYCLES = sns_pkg::TWC_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // two-wire serial link, open drain
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // select and protect pins
  input  wire logic [1:0] busSelectInputs,
  input  wire logic       writeProtect,
  // supply monitor
  input  wire logic       lowSupply,
  output logic            resetN,
  output logic            backupCapacitorPin,
  output logic            standbyMode,
  // nibble parallel port
  input  wire logic       chipEnN,
  input  wire logic       readEnN,
  input  wire logic       writeEnN,
  input  wire logic [3:0] nibbleDataIn,
  output logic      [3:0] nibbleDataOut,
  output logic            nibbleDataOe,
  // mirrored output ports
  output logic      [3:0] mirroredOutputPorts
);

  localparam int TW = sns_pkg::TIMER_W;
  localparam logic [TW-1:0] TIMER_LOAD = TW'(WRITE_CYCLES - 1);

  sns_pkg::sns_pins_s  pinsRaw, syncA_ff, pin;
  sns_pkg::sns_state_e st_ff, nxt_st, pend_ff, nxt_pend;
  sns_pkg::sns_devaddr_s devByte;
  logic        sclD_ff, sdaD_ff;
  logic [3:0]  bitCnt_ff, nxt_bitCnt;
  logic [7:0]  shift_ff, nxt_shift;
  logic [8:0]  addrCnt_ff, nxt_addrCnt;
  logic        sdaOe_ff, nxt_sdaOe;
  logic        pendMsb_ff, nxt_pendMsb;
  logic        mAck_ff, nxt_mAck;
  logic        pageData_ff, nxt_pageData;
  logic        standby_ff, nxt_standby;
  logic [15:0] valid_ff, nxt_valid;
  logic [TW-1:0] timer_ff, nxt_timer;
  logic [4:0]  commitIdx_ff, nxt_commitIdx;
  logic [3:0]  sram_ff, shadow_ff, nibOut_ff;
  logic        nibOe_ff, resetN_ff, cap_ff;
  logic [7:0]  arrayRd, bufRd;

  // two-flop synchroniser for every pin
  assign pinsRaw = {scl, sdaIn, writeProtect, busSelectInputs, lowSupply,
                    chipEnN, readEnN, writeEnN, nibbleDataIn};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_ff <= sns_pkg::PINS_IDLE;
      pin      <= sns_pkg::PINS_IDLE;
      sclD_ff  <= 1'b1;
      sdaD_ff  <= 1'b1;
    end else begin
      syncA_ff <= pinsRaw;
      pin      <= syncA_ff;
      sclD_ff  <= pin.scl;
      sdaD_ff  <= pin.sda;
    end
  end

  // bus events
  wire sclRise = pin.scl & ~sclD_ff;
  wire sclFall = ~pin.scl & sclD_ff;
  wire startEv = pin.scl & sclD_ff & sdaD_ff & ~pin.sda;  // (RULE14)
  wire stopEv  = pin.scl & sclD_ff & ~sdaD_ff & pin.sda;  // (RULE15)

  assign devByte = shift_ff;
  wire addrMatch = (devByte.typeId == DEVICE_TYPE) && (devByte.sel == pin.sel);  // (RULE22)
  wire pageProtected = pin.wp & addrCnt_ff[8];  // (RULE4)
  wire serialState = (st_ff == sns_pkg::S_ADDR) || (st_ff == sns_pkg::S_WORD)
                     || (st_ff == sns_pkg::S_WDATA) || (st_ff == sns_pkg::S_RDATA);
  wire rxState = serialState && (st_ff != sns_pkg::S_RDATA);
  wire rxDecide = sclFall && rxState && (bitCnt_ff == sns_pkg::BIT_ACK) && !pin.low;
  wire txByteEnd = sclFall && (st_ff == sns_pkg::S_RDATA) && (bitCnt_ff == sns_pkg::BIT_ACK)
                   && !pin.low && !startEv && !stopEv;
  wire bufWe = rxDecide && (st_ff == sns_pkg::S_WDATA) && !pageProtected;  // (RULE24)
  wire [3:0] commitPrev = 4'(commitIdx_ff - 5'h01);
  wire commitSlot = (commitIdx_ff != 5'h00) && (commitIdx_ff <= sns_pkg::PAGE_BYTES);
  wire arrayWe = (st_ff == sns_pkg::S_NVWRITE) && commitSlot && valid_ff[commitPrev];

  logic ackGive;
  always_comb begin
    case (st_ff)
      sns_pkg::S_ADDR:  ackGive = addrMatch;       // (RULE18)
      sns_pkg::S_WORD:  ackGive = 1'b1;            // (RULE18)
      sns_pkg::S_WDATA: ackGive = !pageProtected;  // (RULE24)
      default:          ackGive = 1'b0;
    endcase
  end

  always_comb begin
    nxt_st        = st_ff;
    nxt_pend      = pend_ff;
    nxt_bitCnt    = bitCnt_ff;
    nxt_shift     = shift_ff;
    nxt_addrCnt   = addrCnt_ff;
    nxt_sdaOe     = sdaOe_ff;
    nxt_pendMsb   = pendMsb_ff;
    nxt_mAck      = mAck_ff;
    nxt_pageData  = pageData_ff;
    nxt_standby   = standby_ff;
    nxt_valid     = valid_ff;
    nxt_timer     = timer_ff;
    nxt_commitIdx = commitIdx_ff;
    case (st_ff)
      sns_pkg::S_IDLE, sns_pkg::S_ADDR, sns_pkg::S_WORD, sns_pkg::S_WDATA,
      sns_pkg::S_RDATA: begin
        if (pin.low) begin
          nxt_st    = sns_pkg::S_STORE;  // (RULE9) (RULE10)
          nxt_sdaOe = 1'b0;
          nxt_valid = '0;
          nxt_timer = TIMER_LOAD;
        end else if (startEv) begin
          nxt_st       = sns_pkg::S_ADDR;
          nxt_bitCnt   = 4'h0;
          nxt_sdaOe    = 1'b0;
          nxt_standby  = 1'b0;
          nxt_valid    = '0;
          nxt_pageData = 1'b0;
        end else if (stopEv) begin
          nxt_sdaOe = 1'b0;
          // the clock rise that opens the stop already counts as one bit
          if (st_ff == sns_pkg::S_WDATA && pageData_ff && bitCnt_ff == 4'h1) begin
            nxt_st        = sns_pkg::S_NVWRITE;  // (RULE23)
            nxt_timer     = TIMER_LOAD;
            nxt_commitIdx = 5'h00;
          end else begin
            nxt_st      = sns_pkg::S_IDLE;
            nxt_standby = 1'b1;  // (RULE15)
          end
        end else if (st_ff != sns_pkg::S_IDLE) begin
          if (sclRise) begin
            if (bitCnt_ff < sns_pkg::BIT_END) begin
              nxt_bitCnt = bitCnt_ff + 4'h1;
            end
            if (rxState && bitCnt_ff < sns_pkg::BIT_ACK) begin
              nxt_shift = {shift_ff[6:0], pin.sda};
            end
            if (st_ff == sns_pkg::S_RDATA && bitCnt_ff == sns_pkg::BIT_ACK) begin
              nxt_mAck = ~pin.sda;  // (RULE20)
            end
          end else if (sclFall) begin
            if (st_ff == sns_pkg::S_RDATA) begin
              if (bitCnt_ff == sns_pkg::BIT_ACK) begin
                nxt_sdaOe   = 1'b0;  // (RULE17)
                nxt_addrCnt = addrCnt_ff + 9'h001;  // (RULE1) (RULE2)
              end else if (bitCnt_ff == sns_pkg::BIT_END) begin
                if (mAck_ff) begin
                  nxt_shift  = arrayRd;  // (RULE20)
                  nxt_sdaOe  = ~arrayRd[7];
                  nxt_bitCnt = 4'h0;
                end else begin
                  nxt_st = sns_pkg::S_IDLE;  // (RULE20)
                end
              end else if (bitCnt_ff != 4'h0) begin
                nxt_shift = {shift_ff[6:0], 1'b0};
                nxt_sdaOe = ~shift_ff[6];
              end
            end else if (bitCnt_ff == sns_pkg::BIT_ACK) begin
              nxt_sdaOe = ackGive;  // (RULE17)
              if (!ackGive) begin
                nxt_st = sns_pkg::S_IDLE;
              end
              if (st_ff == sns_pkg::S_ADDR) begin
                nxt_pend    = devByte.rw ? sns_pkg::S_RDATA : sns_pkg::S_WORD;
                nxt_pendMsb = devByte.addrMsb;
              end else if (st_ff == sns_pkg::S_WORD) begin
                nxt_addrCnt = {pendMsb_ff, shift_ff};
                nxt_pend    = sns_pkg::S_WDATA;
              end else if (ackGive) begin
                nxt_addrCnt[3:0]           = addrCnt_ff[3:0] + 4'h1;  // (RULE25) (RULE3)
                nxt_pageData               = 1'b1;
                nxt_valid[addrCnt_ff[3:0]] = 1'b1;
              end
            end else if (bitCnt_ff == sns_pkg::BIT_END) begin
              nxt_sdaOe  = 1'b0;
              nxt_bitCnt = 4'h0;
              nxt_st     = pend_ff;
              if (pend_ff == sns_pkg::S_RDATA) begin
                nxt_shift = arrayRd;
                nxt_sdaOe = ~arrayRd[7];
              end
            end
          end
        end
      end
      sns_pkg::S_NVWRITE: begin
        // bus ignored; page buffer drains into the array in the first cycles
        nxt_sdaOe = 1'b0;  // (RULE19) (RULE23)
        if (commitIdx_ff <= sns_pkg::PAGE_BYTES) begin
          nxt_commitIdx = commitIdx_ff + 5'h01;
        end
        nxt_timer = timer_ff - TW'(1);
        if (timer_ff == '0) begin
          nxt_valid   = '0;
          nxt_standby = 1'b1;
          nxt_st      = pin.low ? sns_pkg::S_STORE : sns_pkg::S_IDLE;  // (RULE11)
          nxt_timer   = TIMER_LOAD;
        end
      end
      sns_pkg::S_STORE: begin
        nxt_timer = timer_ff - TW'(1);
        if (timer_ff == '0) begin
          nxt_st = sns_pkg::S_DOWN;
        end
      end
      sns_pkg::S_DOWN: begin
        if (!pin.low) begin
          nxt_st      = sns_pkg::S_IDLE;
          nxt_standby = 1'b1;
        end
      end
      default: nxt_st = sns_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff        <= sns_pkg::S_IDLE;
      pend_ff      <= sns_pkg::S_IDLE;
      bitCnt_ff    <= 4'h0;
      shift_ff     <= 8'h00;
      addrCnt_ff   <= sns_pkg::ADDR_RESET;
      sdaOe_ff     <= 1'b0;
      pendMsb_ff   <= 1'b0;
      mAck_ff      <= 1'b0;
      pageData_ff  <= 1'b0;
      standby_ff   <= 1'b1;
      valid_ff     <= '0;
      timer_ff     <= '0;
      commitIdx_ff <= 5'h00;
    end else begin
      st_ff        <= nxt_st;
      pend_ff      <= nxt_pend;
      bitCnt_ff    <= nxt_bitCnt;
      shift_ff     <= nxt_shift;
      addrCnt_ff   <= nxt_addrCnt;
      sdaOe_ff     <= nxt_sdaOe;
      pendMsb_ff   <= nxt_pendMsb;
      mAck_ff      <= nxt_mAck;
      pageData_ff  <= nxt_pageData;
      standby_ff   <= nxt_standby;
      valid_ff     <= nxt_valid;
      timer_ff     <= nxt_timer;
      commitIdx_ff <= nxt_commitIdx;
    end
  end

  sns_mem #(.AW(sns_pkg::ARRAY_AW), .DW(sns_pkg::BYTE_W)) u_array (
    .clk    (clk),
    .rstn   (rstn),
    .wrEn   (arrayWe),
    .wrAddr ({addrCnt_ff[8:4], commitPrev}),
    .wrData (bufRd),
    .rdAddr (addrCnt_ff),
    .rdData (arrayRd)
  );

  sns_mem #(.AW(sns_pkg::PAGE_AW), .DW(sns_pkg::BYTE_W)) u_page (
    .clk    (clk),
    .rstn   (rstn),
    .wrEn   (bufWe),
    .wrAddr (addrCnt_ff[3:0]),
    .wrData (shift_ff),
    .rdAddr (commitIdx_ff[3:0]),
    .rdData (bufRd)
  );

  // nibble store, shadow and supply outputs
  wire nibAlive = !pin.low && (st_ff != sns_pkg::S_STORE) && (st_ff != sns_pkg::S_DOWN);
  wire nibWrite = nibAlive && !pin.strb.chipEnN && !pin.strb.writeEnN;  // (RULE26) (RULE5)
  wire nibRead  = nibAlive && !pin.strb.chipEnN && !pin.strb.readEnN && pin.strb.writeEnN;
  wire recall   = (st_ff == sns_pkg::S_DOWN) && !pin.low;  // (RULE6)
  wire storeEnd = (st_ff == sns_pkg::S_STORE) && (timer_ff == '0);  // (RULE6)

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sram_ff   <= sns_pkg::NIB_RESET;
      shadow_ff <= sns_pkg::NIB_RESET;
      nibOut_ff <= sns_pkg::NIB_RESET;
      nibOe_ff  <= 1'b0;
      resetN_ff <= 1'b1;
      cap_ff    <= 1'b0;
    end else begin
      sram_ff   <= recall ? shadow_ff : (nibWrite ? pin.nib : sram_ff);
      shadow_ff <= storeEnd ? sram_ff : shadow_ff;
      nibOut_ff <= sram_ff;
      nibOe_ff  <= nibRead;  // (RULE26)
      resetN_ff <= ~pin.low;  // (RULE8)
      cap_ff    <= (nxt_st == sns_pkg::S_STORE);  // (RULE9)
    end
  end

  assign sdaOut              = 1'b0;
  assign sdaOe               = sdaOe_ff;
  assign standbyMode         = standby_ff;
  assign resetN              = resetN_ff;
  assign backupCapacitorPin  = cap_ff;
  assign nibbleDataOut       = nibOut_ff;
  assign nibbleDataOe        = nibOe_ff;
  assign mirroredOutputPorts = sram_ff;  // (RULE7)

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  reset_out_a: assert property (pin.low |=> !resetN) else $error("reset not driven"); // (RULE8)
  store_start_a: assert property ((pin.low && (serialState || st_ff == sns_pkg::S_IDLE))
    |=> st_ff == sns_pkg::S_STORE && backupCapacitorPin) else $error("no store"); // (RULE9)
  abort_release_a: assert property (pin.low |=> ##1 !sdaOe) else $error("link kept"); // (RULE10)
  nv_finish_a: assert property ((st_ff == sns_pkg::S_NVWRITE && pin.low && timer_ff != '0)
    |=> st_ff == sns_pkg::S_NVWRITE) else $error("write cut short"); // (RULE11)
  busy_float_a: assert property (st_ff == sns_pkg::S_NVWRITE |=> !sdaOe) else $error("busy ack"); // (RULE19)
  protect_block_a: assert property ((rxDecide && st_ff == sns_pkg::S_WDATA && pin.wp
    && addrCnt_ff[8]) |-> !bufWe ##1 (!sdaOe && st_ff == sns_pkg::S_IDLE))
    else $error("protected write taken"); // (RULE4)
  page_wrap_a: assert property (bufWe |=> addrCnt_ff[8:4] == $past(addrCnt_ff[8:4])
    && addrCnt_ff[3:0] == 4'($past(addrCnt_ff[3:0]) + 4'h1)) else $error("wrap"); // (RULE25)
  read_incr_a: assert property (txByteEnd |=> addrCnt_ff == 9'($past(addrCnt_ff) + 9'h001))
    else $error("read counter"); // (RULE1)
  idle_ignore_a: assert property ((st_ff == sns_pkg::S_IDLE && !startEv && !pin.low)
    |=> st_ff == sns_pkg::S_IDLE && !sdaOe) else $error("idle left"); // (RULE14)
  addr_nack_a: assert property ((rxDecide && st_ff == sns_pkg::S_ADDR && !addrMatch)
    |=> !sdaOe && st_ff == sns_pkg::S_IDLE) else $error("false ack"); // (RULE18)
  sda_timing_a: assert property (($changed(sdaOe) && !$past(pin.low) && !$past(stopEv))
    |-> !$past(pin.scl)) else $error("sda moved with scl high"); // (RULE13)
  read_stop_a: assert property ((stopEv && !pin.low
    && (st_ff == sns_pkg::S_RDATA || st_ff == sns_pkg::S_IDLE))
    |=> st_ff == sns_pkg::S_IDLE && standbyMode) else $error("standby"); // (RULE15)
  nib_read_a: assert property (nibRead ##1 nibRead |=> nibbleDataOe
    && nibbleDataOut == $past(mirroredOutputPorts)) else $error("nibble read"); // (RULE26)

  page_commit_c: cover property (arrayWe);
  seq_read_c: cover property (txByteEnd ##[1:1000] (sclFall && mAck_ff && bitCnt_ff == 4'h9));
  power_fail_c: cover property (storeEnd ##[1:1000] recall);
  nib_write_c: cover property (nibWrite ##[1:50] nibRead);

endmodule
